// ### nsrs_pkg.sv
// package: pin, request and timing definitions for the nvsram host sequencer
`default_nettype none
package nsrs_pkg;

  // ==========================================================
  // widths
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int CNT_W = 24;
  localparam int SEQ_LEN = 6;
  localparam int SYNC_DEPTH = 3;

  // ==========================================================
  // clock and printed times
  localparam int CLK_PERIOD_NS = 50;
  localparam int READ_CYCLE_TIME_NS = 25;
  localparam int CE_PULSE_NS = 20;
  localparam int WRITE_PULSE_NS = 50;
  localparam int SAVE_CYCLE_TIME_MS = 10;
  localparam int RESTORE_CYCLE_TIME_US = 20;
  localparam int POWERUP_RESTORE_TIME_US = 550;

  // least times round up, none below one cycle
  localparam int READ_ACC_CYC = (READ_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CE_PULSE_CYC = (CE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_PULSE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // the read data also crosses the pin synchroniser before it is trusted
  localparam int RD_HOLD_CYC = READ_ACC_CYC + SYNC_DEPTH;
  localparam int SAVE_CYC = SAVE_CYCLE_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int RESTORE_CYC = (RESTORE_CYCLE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PWRUP_CYC = (POWERUP_RESTORE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================
  // sequence addresses, lower 14 bits only
  localparam logic [13:0] SEQ_ADDR_0 = 14'h0e38;
  localparam logic [13:0] SEQ_ADDR_1 = 14'h31c7;
  localparam logic [13:0] SEQ_ADDR_2 = 14'h03e0;
  localparam logic [13:0] SEQ_ADDR_3 = 14'h3c1f;
  localparam logic [13:0] SEQ_ADDR_4 = 14'h303f;
  localparam logic [13:0] SEQ_ADDR_SAVE = 14'h0fc0;
  localparam logic [13:0] SEQ_ADDR_RESTORE = 14'h0c63;

  // ==========================================================
  // pin reset values
  localparam logic PIN_IDLE_N = 1'b1;

  // ==========================================================
  // commands and states
  typedef enum logic [1:0] {
    NSRS_OP_READ = 2'h0,
    NSRS_OP_WRITE = 2'h1,
    NSRS_OP_SAVE = 2'h2,
    NSRS_OP_RESTORE = 2'h3
  } nsrs_op_t;

  typedef enum logic [8:0] {
    NSRS_ST_PWRUP = 9'h001,
    NSRS_ST_IDLE = 9'h002,
    NSRS_ST_RD_LOW = 9'h004,
    NSRS_ST_WR_SETUP = 9'h008,
    NSRS_ST_WR_LOW = 9'h010,
    NSRS_ST_WR_END = 9'h020,
    NSRS_ST_SEQ_SETUP = 9'h040,
    NSRS_ST_SEQ_LOW = 9'h080,
    NSRS_ST_NV_WAIT = 9'h100
  } nsrs_state_t;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic cs_n;
    logic oe_n;
    logic we_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_out;
    logic dq_oe;
  } nsrs_pins_t;

  typedef struct packed {
    nsrs_op_t op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } nsrs_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic err;
  } nsrs_rsp_t;

endpackage
`default_nettype wire

// ### nsrs_sync.sv
// three-stage pin synchroniser with an agreement flag
`timescale 1ns/100ps
`default_nettype none
module nsrs_sync
  import nsrs_pkg::*;
#(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // pin side
  input wire logic [WIDTH-1:0] pin_in,
  // synchronous side
  output logic [WIDTH-1:0] value,
  output logic stable
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
  } nsrs_sync_state_t;

  nsrs_sync_state_t q, d;

  // ==========================================================
  // stage shift; s1 feeds s2 only, metastability stays there
  always_comb begin
    d = q;
    d.s1 = pin_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // a change counts once the last two stages agree
  assign value = q.s3;
  assign stable = (q.s2 == q.s3);

endmodule
`default_nettype wire

// ### nsrs_host.sv
// host controller for a nonvolatile shadowed static ram: access, save, restore
`timescale 1ns/100ps
`default_nettype none
module nsrs_host
  import nsrs_pkg::*;
#(
  parameter logic [CNT_W-1:0] SAVE_WAIT_CYC = CNT_W'(SAVE_CYC),
  parameter logic [CNT_W-1:0] PWRUP_WAIT_CYC = CNT_W'(PWRUP_CYC)
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // user request port
  input wire logic req_valid,
  input wire nsrs_req_t req,
  output logic req_ready,
  // user answer port
  output logic rsp_valid,
  output nsrs_rsp_t rsp,
  output logic busy,
  // supply indication from the board
  input wire logic supply_ok,
  // memory pins
  output nsrs_pins_t pins,
  input wire logic [DATA_W-1:0] dq_in
);

  typedef struct packed {
    nsrs_state_t st;
    logic [CNT_W-1:0] cnt;
    logic [2:0] step;
    nsrs_op_t op;
    logic supply_lost;
    logic ready;
    logic rsp_valid;
    nsrs_rsp_t rsp;
    logic busy;
    nsrs_pins_t pins;
  } nsrs_host_state_t;

  localparam nsrs_pins_t PINS_IDLE = '{cs_n: PIN_IDLE_N, oe_n: PIN_IDLE_N,
                                       we_n: PIN_IDLE_N, addr: '0, dq_out: '0,
                                       dq_oe: 1'b0};

  nsrs_host_state_t q, d;
  logic [DATA_W-1:0] dq_sync;
  logic dq_stable;
  logic supply_sync;

  // ==========================================================
  // pin synchronisers
  nsrs_sync #(
    .WIDTH(DATA_W)
  ) u_dq_sync (
    .clk(clk),
    .nrst(nrst),
    .pin_in(dq_in),
    .value(dq_sync),
    .stable(dq_stable)
  );

  nsrs_sync #(
    .WIDTH(1)
  ) u_supply_sync (
    .clk(clk),
    .nrst(nrst),
    .pin_in(supply_ok),
    .value(supply_sync),
    .stable()
  );

  // ==========================================================
  // sequence address for a step; top address line held low
  // lower fourteen bits
  function automatic logic [ADDR_W-1:0] seq_addr(input logic [2:0] step, input nsrs_op_t op);
    logic [13:0] a;
    a = SEQ_ADDR_0;
    case (step)
      3'h0: a = SEQ_ADDR_0;
      3'h1: a = SEQ_ADDR_1;
      3'h2: a = SEQ_ADDR_2;
      3'h3: a = SEQ_ADDR_3;
      3'h4: a = SEQ_ADDR_4;
      default: a = (op == NSRS_OP_SAVE) ? SEQ_ADDR_SAVE : SEQ_ADDR_RESTORE;
    endcase
    return {1'b0, a};
  endfunction

  // ==========================================================
  // main sequencer
  always_comb begin
    d = q;
    d.rsp_valid = 1'b0;
    case (q.st)
      NSRS_ST_PWRUP: begin
        d.pins = PINS_IDLE;
        if (q.cnt == '0) begin
          d.st = NSRS_ST_IDLE;
          d.ready = 1'b1;
          d.busy = 1'b0;
        end else begin
          d.cnt = q.cnt - CNT_W'(1);
        end
      end
      NSRS_ST_IDLE: begin
        if (req_valid) begin
          d.op = req.op;
          d.ready = 1'b0;
          d.busy = 1'b1;
          d.step = 3'h0;
          d.supply_lost = 1'b0;
          d.rsp.err = 1'b0;
          case (req.op)
            NSRS_OP_READ: begin
              // read with gate low, strobe high
              d.pins.addr = req.addr;
              d.pins.cs_n = 1'b0;
              d.pins.oe_n = 1'b0;
              d.cnt = CNT_W'(RD_HOLD_CYC - 1);
              d.st = NSRS_ST_RD_LOW;
            end
            NSRS_OP_WRITE: begin
              // address and data settle before select falls
              d.pins.addr = req.addr;
              d.pins.dq_out = req.wdata;
              d.pins.dq_oe = 1'b1;
              d.st = NSRS_ST_WR_SETUP;
            end
            default: begin
              // no save sequence while supply low
              if (req.op == NSRS_OP_SAVE && !supply_sync) begin
                d.rsp.err = 1'b1;
                d.rsp_valid = 1'b1;
                d.ready = 1'b1;
                d.busy = 1'b0;
              end else begin
                // every sequence starts from step one
                d.pins.addr = seq_addr(3'h0, req.op);
                d.st = NSRS_ST_SEQ_SETUP;
              end
            end
          endcase
        end
      end
      // select and gate stay low while data settles
      NSRS_ST_RD_LOW: begin
        if (q.cnt != '0) begin
          d.cnt = q.cnt - CNT_W'(1);
        end else if (dq_stable) begin
          d.rsp.rdata = dq_sync;
          d.pins.cs_n = 1'b1;
          d.pins.oe_n = 1'b1;
          d.rsp_valid = 1'b1;
          d.ready = 1'b1;
          d.busy = 1'b0;
          d.st = NSRS_ST_IDLE;
        end
      end
      NSRS_ST_WR_SETUP: begin
        d.pins.cs_n = 1'b0;
        d.pins.we_n = 1'b0;
        d.cnt = CNT_W'(WR_PULSE_CYC - 1);
        d.st = NSRS_ST_WR_LOW;
      end
      NSRS_ST_WR_LOW: begin
        if (q.cnt != '0) begin
          d.cnt = q.cnt - CNT_W'(1);
        end else begin
          // rising strobes store the byte; address and data still held
          d.pins.cs_n = 1'b1;
          d.pins.we_n = 1'b1;
          d.st = NSRS_ST_WR_END;
        end
      end
      NSRS_ST_WR_END: begin
        d.pins.dq_oe = 1'b0;
        d.rsp_valid = 1'b1;
        d.ready = 1'b1;
        d.busy = 1'b0;
        d.st = NSRS_ST_IDLE;
      end
      // address set while select high, then a select-delimited read
      NSRS_ST_SEQ_SETUP: begin
        // output gate left high, data is not wanted
        d.pins.cs_n = 1'b0;
        d.cnt = CNT_W'(CE_PULSE_CYC - 1);
        d.st = NSRS_ST_SEQ_LOW;
      end
      NSRS_ST_SEQ_LOW: begin
        if (q.cnt != '0) begin
          d.cnt = q.cnt - CNT_W'(1);
        end else begin
          d.pins.cs_n = 1'b1;
          // six reads back to back, nothing in between
          if (q.step == 3'(SEQ_LEN - 1)) begin
            d.cnt = (q.op == NSRS_OP_SAVE) ? SAVE_WAIT_CYC - CNT_W'(1)
                                           : CNT_W'(RESTORE_CYC - 1);
            d.st = NSRS_ST_NV_WAIT;
          end else begin
            d.step = q.step + 3'h1;
            d.pins.addr = seq_addr(q.step + 3'h1, q.op);
            d.st = NSRS_ST_SEQ_SETUP;
          end
        end
      end
      // device locked out; pins parked, no access issued
      NSRS_ST_NV_WAIT: begin
        // a supply drop spoils a save; it is reported, wait still runs
        if (q.op == NSRS_OP_SAVE && !supply_sync) begin
          d.supply_lost = 1'b1;
        end
        if (q.cnt != '0) begin
          d.cnt = q.cnt - CNT_W'(1);
        end else begin
          // access allowed again after the cycle time
          d.rsp.err = d.supply_lost;
          d.rsp_valid = 1'b1;
          d.ready = 1'b1;
          d.busy = 1'b0;
          d.st = NSRS_ST_IDLE;
        end
      end
      default: begin
        d.pins = PINS_IDLE;
        d.ready = 1'b1;
        d.busy = 1'b0;
        d.st = NSRS_ST_IDLE;
      end
    endcase
  end

  // reset enters the power-up wait with every strobe inactive
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q <= '{st: NSRS_ST_PWRUP, cnt: PWRUP_WAIT_CYC, step: 3'h0, op: NSRS_OP_READ,
             supply_lost: 1'b0, ready: 1'b0, rsp_valid: 1'b0, rsp: '0, busy: 1'b1,
             pins: PINS_IDLE};
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // outputs straight from the state register
  assign req_ready = q.ready;
  assign rsp_valid = q.rsp_valid;
  assign rsp = q.rsp;
  assign busy = q.busy;
  assign pins = q.pins;

endmodule
`default_nettype wire

// ### nsrs_host_sva.sv
// checker: port-level assertions for the nvsram host sequencer
`timescale 1ns/100ps
`default_nettype none
module nsrs_host_sva
  import nsrs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // user side
  input wire logic req_valid,
  input wire nsrs_req_t req,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire nsrs_rsp_t rsp,
  input wire logic busy,
  input wire logic supply_ok,
  // memory pins
  input wire nsrs_pins_t pins,
  input wire logic [DATA_W-1:0] dq_in
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // ==========================================
  // sequences
  sequence take(nsrs_op_t o);
    req_valid && req_ready && req.op == o;
  endsequence
  // one select-delimited read, output gate high so no read contention
  sequence step(logic [13:0] a);
    pins.cs_n && pins.addr == {1'b0, a} ##1 !pins.cs_n && pins.oe_n && pins.we_n;
  endsequence
  sequence seq5;
    step(SEQ_ADDR_0) ##1 step(SEQ_ADDR_1) ##1 step(SEQ_ADDR_2) ##1 step(SEQ_ADDR_3)
      ##1 step(SEQ_ADDR_4);
  endsequence
  // ==========================================
  // properties
  a_restore_seq: assert property (
    take(NSRS_OP_RESTORE) |=> seq5 ##1 step(SEQ_ADDR_RESTORE) ##1 pins.cs_n)
    else $error("restore sequence wrong");
  a_save_seq: assert property (
    supply_ok [*5] ##0 take(NSRS_OP_SAVE) |=> seq5 ##1 step(SEQ_ADDR_SAVE) ##1 pins.cs_n)
    else $error("save sequence wrong");
  a_save_refuse: assert property (
    (!supply_ok) [*5] ##0 take(NSRS_OP_SAVE) |=> rsp_valid && rsp.err)
    else $error("save not refused");
  a_read_walk: assert property (
    take(NSRS_OP_READ) |=> pins.addr == $past(req.addr) && !pins.cs_n && !pins.oe_n
      && pins.we_n ##1 (!pins.cs_n && !pins.oe_n) [*3] ##[1:16] rsp_valid && pins.cs_n)
    else $error("read walk wrong");
  a_write_walk: assert property (
    take(NSRS_OP_WRITE) |=> pins.dq_oe && pins.dq_out == $past(req.wdata) ##1
      !pins.cs_n && !pins.we_n ##1 pins.cs_n && pins.we_n && pins.dq_oe ##1
      rsp_valid && !pins.dq_oe)
    else $error("write walk wrong");
  a_write_hold: assert property (
    !pins.cs_n && !pins.we_n |=> $stable(pins.addr) && $stable(pins.dq_out))
    else $error("write address or data moved");
  a_write_gate: assert property (
    !pins.we_n |-> pins.oe_n && pins.dq_oe)
    else $error("gate low during write");
  a_gate_float: assert property (
    !pins.oe_n |-> !pins.dq_oe && pins.we_n)
    else $error("host drives during read");
  a_answer_ready: assert property (
    rsp_valid |-> req_ready && !busy)
    else $error("answer without ready");
endmodule
bind nsrs_host nsrs_host_sva u_sva (.clk(clk), .nrst(nrst), .req_valid(req_valid),
  .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp), .busy(busy),
  .supply_ok(supply_ok), .pins(pins), .dq_in(dq_in));
`default_nettype wire

// ### nsrs_nvram_model.sv
// behavioural model of the shadowed static ram seen from its pins
`timescale 1ns/100ps
`default_nettype none
module nsrs_nvram_model
  import nsrs_pkg::*;
#(
  parameter int SAVE_LK = 15,
  parameter int RCL_LK = 20,
  parameter int PWR_LK = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // board and pins
  input wire logic supply_ok,
  input wire nsrs_pins_t pins,
  output logic [DATA_W-1:0] dq_in
);
  localparam logic [13:0] SQ [5] = '{SEQ_ADDR_0, SEQ_ADDR_1, SEQ_ADDR_2, SEQ_ADDR_3, SEQ_ADDR_4};
  logic [7:0] mem [32768];
  logic [7:0] nv [32768];
  nsrs_pins_t p;
  int step;
  int lock;
  logic saving;
  logic [7:0] last;
  logic rd;
  logic [13:0] pa;
  initial nv = '{default: 8'h00};
  // drive only on enabled read; released bus toggles
  assign rd = !pins.cs_n && !pins.oe_n && pins.we_n && lock == 0;
  assign dq_in = rd ? mem[pins.addr] : ~last;
  assign pa = p.addr[13:0];
  // power-up restore; lockout then strobe edges
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mem = nv;
      lock <= PWR_LK;
      step <= 0;
      saving <= 1'b0;
      last <= 8'h00;
      p <= '1;
    end else begin
      p <= pins;
      last <= dq_in;
      // locked: pins ignored; save dropped on low supply
      if (lock > 0) begin
        lock <= lock - 1;
        if (saving && !supply_ok) saving <= 1'b0;
        // erase and program at the end
        if (lock == 1 && saving && supply_ok) begin
          nv = mem;
          saving <= 1'b0;
        end
      // store at strobe rise; a write aborts the sequence
      end else if (!p.cs_n && !p.we_n && (pins.cs_n || pins.we_n)) begin
        mem[p.addr] <= p.dq_out;
        step <= 0;
      end else if (!p.cs_n && pins.cs_n && p.we_n) begin
        if (step == 5 && pa == SEQ_ADDR_SAVE) begin
          step <= 0;
          saving <= supply_ok;
          lock <= supply_ok ? SAVE_LK : 0;
        end else if (step == 5 && pa == SEQ_ADDR_RESTORE) begin
          step <= 0;
          mem = nv;
          lock <= RCL_LK;
        end else if (step < 5 && pa == SQ[step]) step <= step + 1;
        else step <= (pa == SEQ_ADDR_0) ? 1 : 0;
      end
    end
  end
endmodule
`default_nettype wire

// ### test_nsrs_host.sv
// self-checking testbench for the nvsram host sequencer
`timescale 1ns/100ps
`default_nettype none
module test_nsrs_host
  import nsrs_pkg::*;
;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic req_valid = 1'b0;
  logic supply_ok = 1'b1;
  nsrs_req_t req = '0;
  logic req_ready, rsp_valid, busy;
  nsrs_rsp_t rsp, rr;
  nsrs_pins_t pins;
  logic [DATA_W-1:0] dq_in;
  int errors = 0;
  int n_checks = 0;
  // short waits keep the run small
  nsrs_host #(.SAVE_WAIT_CYC(24'h14), .PWRUP_WAIT_CYC(24'ha)) uut (.clk(clk), .nrst(nrst),
    .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp(rsp), .busy(busy), .supply_ok(supply_ok), .pins(pins), .dq_in(dq_in));
  nsrs_nvram_model u_mem (.clk(clk), .nrst(nrst), .supply_ok(supply_ok), .pins(pins),
    .dq_in(dq_in));
  always #25 clk = ~clk;
  // ==========================================
  // helpers
  task automatic chk_d(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %0t data %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_b(input logic g, input logic e);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %0t flag %b exp %b", $time, g, e);
    end
  endtask
  // one request held until taken, then wait for its answer
  task automatic xfer(input nsrs_op_t o, input logic [14:0] a, input logic [7:0] d);
    int n;
    n = 0;
    req_valid <= 1'b1;
    req <= '{o, a, d};
    do begin @(posedge clk); n++; end while (req_ready !== 1'b1 && n < 9);
    req_valid <= 1'b0;
    if (req_ready !== 1'b1) begin
      errors++;
      $display("[FAIL] %0t request not taken", $time);
    end
    do begin @(posedge clk); n++; end while (rsp_valid !== 1'b1 && n < 999);
    if (n >= 999) begin
      errors++;
      $display("[FAIL] %0t no answer", $time);
    end
    rr = rsp;
  endtask
  task automatic rd_chk(input logic [14:0] a, input logic [7:0] e);
    xfer(NSRS_OP_READ, a, 8'h00);
    chk_d(rr.rdata, e);
  endtask
  task automatic nv_chk(input nsrs_op_t o, input logic e);
    xfer(o, 15'h0000, 8'h00);
    chk_b(rr.err, e);
  endtask
  task automatic complete_run;
    $display("errors %0d checks %0d", errors, n_checks);
    if (errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset;
    int n;
    n = 0;
    repeat (3) @(posedge clk);
    chk_b(busy, 1'b1);
    nrst <= 1'b1;
    repeat (9) @(posedge clk);
    chk_b(req_ready, 1'b0);
    chk_b(pins.we_n, 1'b1);
    do begin @(posedge clk); n++; end while (req_ready !== 1'b1 && n < 20);
    chk_b(busy, 1'b0);
    chk_b(req_ready, 1'b1);
  endtask
  // boundary addresses and a sequence address with the top line set
  task automatic t_rw;
    logic [14:0] ad [3];
    ad = '{15'h0000, 15'h7fff, 15'h4e38};
    for (int i = 0; i < 3; i++) xfer(NSRS_OP_WRITE, ad[i], 8'h5a + 8'(i));
    for (int i = 0; i < 3; i++) rd_chk(ad[i], 8'h5a + 8'(i));
  endtask
  task automatic t_nv;
    xfer(NSRS_OP_WRITE, 15'h0005, 8'h11);
    nv_chk(NSRS_OP_SAVE, 1'b0);
    xfer(NSRS_OP_WRITE, 15'h0005, 8'h22);
    rd_chk(15'h0005, 8'h22);
    repeat (2) begin
      nv_chk(NSRS_OP_RESTORE, 1'b0);
      rd_chk(15'h0005, 8'h11);
    end
  endtask
  // refused save, then a save spoiled by a supply drop mid-wait
  task automatic t_inh;
    supply_ok <= 1'b0;
    repeat (6) @(posedge clk);
    nv_chk(NSRS_OP_SAVE, 1'b1);
    supply_ok <= 1'b1;
    repeat (6) @(posedge clk);
    xfer(NSRS_OP_WRITE, 15'h0005, 8'h33);
    fork
      nv_chk(NSRS_OP_SAVE, 1'b1);
      begin
        repeat (28) @(posedge clk);
        supply_ok <= 1'b0;
      end
    join
    supply_ok <= 1'b1;
    repeat (6) @(posedge clk);
    nv_chk(NSRS_OP_RESTORE, 1'b0);
    rd_chk(15'h0005, 8'h11);
  endtask
  // a second power-up mid-run brings back the saved copy, not the last write
  task automatic t_rst2;
    int n;
    n = 0;
    xfer(NSRS_OP_WRITE, 15'h0005, 8'h44);
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    chk_b(req_ready, 1'b0);
    nrst <= 1'b1;
    do begin @(posedge clk); n++; end while (req_ready !== 1'b1 && n < 20);
    chk_b(req_ready, 1'b1);
    chk_b(pins.we_n, 1'b1);
    rd_chk(15'h0005, 8'h11);
  endtask
  initial begin
    t_reset();
    t_rw();
    t_nv();
    t_inh();
    t_rst2();
    complete_run();
  end
  // run needs about 1500 cycles; this cuts a hang
  initial begin
    #500000;
    errors++;
    $display("[FAIL] %0t timeout", $time);
    complete_run();
  end
endmodule
`default_nettype wire
